// file: design/psli_top.sv
// front panel led logic for data, speech and teleprotection modules
`timescale 1ns/100ps
module psli_top
	import psli_pkg::*;
#(
	parameter int TICK_CYC = PSLI_TICK_CYC
)
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	// data ports (line levels, asynchronous)
	input wire logic [PSLI_NPORT-1:0] i_port_txd,
	input wire logic [PSLI_NPORT-1:0] i_port_rxd,
	input wire logic [PSLI_NPORT-1:0] i_port_loop,
	input wire logic [PSLI_NPORT-1:0] i_port_disabled,
	output logic [PSLI_NPORT-1:0] o_port_tx_led,
	output logic [PSLI_NPORT-1:0] o_port_rx_led,
	// speech ports signalling wires
	input wire logic [PSLI_NSPEECH-1:0] i_speech_tx_wire,
	input wire logic [PSLI_NSPEECH-1:0] i_speech_rx_wire,
	output logic [PSLI_NSPEECH-1:0] o_speech_tx_led,
	output logic [PSLI_NSPEECH-1:0] o_speech_rx_led,
	// teleprotection status
	input wire logic i_guard_high,
	input wire logic i_guard_low,
	input wire logic i_guard_below_min,
	input wire logic i_signal_present,
	input wire logic [PSLI_NCMD-1:0] i_cmd_tx,
	input wire logic [PSLI_NCMD-1:0] i_cmd_rx,
	input wire logic i_low_snr,
	input wire logic i_test_fail_alarm,
	input wire logic i_device_error,
	input wire logic i_manual_block,
	input wire logic i_config_bad,
	input wire logic i_mgmt_out_block,
	input wire logic i_loop_test_active,
	input wire logic i_test_done,
	input wire logic i_test_pass,
	output logic o_guard_level_ok_led,
	output logic o_signal_loss_led,
	output logic o_rx_blocked,
	output logic o_terminal_alarm_led,
	output logic o_loop_led,
	output logic o_blocking_led,
	output logic o_test_green_led,
	output logic o_test_red_led,
	output logic [PSLI_NCMD-1:0] o_command_transmit_leds,
	output logic [PSLI_NCMD-1:0] o_command_receive_leds
);
	// four vectors per data port, two per speech and command group, 13 single flags
	localparam int NIN = 4 * PSLI_NPORT + 2 * PSLI_NSPEECH + 2 * PSLI_NCMD + 13;

	logic [NIN-1:0] raw_in, syn_in;
	logic [PSLI_NPORT-1:0] txd_s, rxd_s, loop_s, dis_s;
	logic [PSLI_NSPEECH-1:0] stx_s, srx_s;
	logic [PSLI_NCMD-1:0] ctx_s, crx_s;
	logic ghi_s, glo_s, gmin_s, sig_s, snr_s, tfail_s, derr_s, mblk_s;
	logic cfg_s, mgmt_s, ltst_s, tdone_s, tpass_s;
	logic tick, loop_ph, dis_ph;

	// every status flag is a pin, so all pass through the synchroniser
	assign raw_in = {i_port_txd, i_port_rxd, i_port_loop, i_port_disabled,
		i_speech_tx_wire, i_speech_rx_wire, i_cmd_tx, i_cmd_rx,
		i_guard_high, i_guard_low, i_guard_below_min, i_signal_present,
		i_low_snr, i_test_fail_alarm, i_device_error, i_manual_block,
		i_config_bad, i_mgmt_out_block, i_loop_test_active, i_test_done,
		i_test_pass};

	psli_sync #(.W(NIN)) u_sync (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_async(raw_in),
		.o_sync(syn_in)
	);

	// unpack in the same order as the packing above
	assign {txd_s, rxd_s, loop_s, dis_s, stx_s, srx_s, ctx_s, crx_s,
		ghi_s, glo_s, gmin_s, sig_s, snr_s, tfail_s, derr_s, mblk_s,
		cfg_s, mgmt_s, ltst_s, tdone_s, tpass_s} = syn_in;

	psli_timebase #(.TICK_CYC(TICK_CYC)) u_tb (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.o_tick(tick),
		.o_loop_phase(loop_ph),
		.o_dis_phase(dis_ph)
	);

	// data port led state
	logic [PSLI_NPORT-1:0] ptx_r, ptx_nxt, prx_r, prx_nxt;

	genvar gp;
	generate
		for (gp = 0; gp < PSLI_NPORT; gp++)
		begin : g_port
			// disabled wins over loop, loop wins over activity
			always_comb
			begin
				if (dis_s[gp])
				begin
					ptx_nxt[gp] = dis_ph;
					prx_nxt[gp] = dis_ph;
				end
				else if (loop_s[gp])
				begin
					ptx_nxt[gp] = loop_ph;
					prx_nxt[gp] = ~loop_ph;
				end
				else
				begin
					ptx_nxt[gp] = ~txd_s[gp];
					prx_nxt[gp] = ~rxd_s[gp];
				end
			end
		end
	endgenerate

	// millisecond loss timers
	logic [PSLI_MS_W-1:0] gl_r, gl_nxt, pu_r, pu_nxt;
	logic gloss_r, gloss_nxt, puloss_r, puloss_nxt, pwrup_r, pwrup_nxt;
	logic guard_start, cmd_any;

	assign cmd_any = |crx_s;
	assign guard_start = gmin_s & ~cmd_any;

	// guard loss timer clears as soon as its start condition drops
	always_comb
	begin
		gl_nxt = gl_r;
		gloss_nxt = gloss_r;
		if (!guard_start)
		begin
			gl_nxt = PSLI_MS_ZERO;
			gloss_nxt = 1'b0;
		end
		else if (tick && !gloss_r)
		begin
			if (gl_r == PSLI_MS_W'(PSLI_GUARD_LOSS_MS - 1))
				gloss_nxt = 1'b1;
			else
				gl_nxt = gl_r + 10'h001;
		end
	end

	// power-up window: armed from reset until any signal is first seen
	always_comb
	begin
		pu_nxt = pu_r;
		puloss_nxt = puloss_r;
		pwrup_nxt = pwrup_r;
		if (sig_s || cmd_any)
		begin
			pwrup_nxt = 1'b0; // first reception ends the power-up phase
			pu_nxt = PSLI_MS_ZERO;
			puloss_nxt = 1'b0;
		end
		else if (pwrup_r && tick && !puloss_r)
		begin
			// strictly longer than the limit: fires on the tick after it
			if (pu_r == PSLI_MS_W'(PSLI_PWRUP_LOSS_MS))
				puloss_nxt = 1'b1;
			else
				pu_nxt = pu_r + 10'h001;
		end
	end

	// test result held until the next completed test
	psli_test_t tst_r, tst_nxt;
	logic tgreen_r, tgreen_nxt, tred_r, tred_nxt;

	// a fresh result overwrites the old one; both colours stay dark before any test
	always_comb
	begin
		tst_nxt = tst_r;
		if (tdone_s)
			tst_nxt = tpass_s ? PSLI_TST_PASS : PSLI_TST_FAIL;
		tgreen_nxt = (tst_nxt == PSLI_TST_PASS);
		tred_nxt = (tst_nxt == PSLI_TST_FAIL);
	end

	// teleprotection led outputs, all registered
	logic blk_nxt, alarm_nxt, gok_nxt, loss_nxt, loopled_nxt, blkled_nxt;
	logic blk_r, alarm_r, gok_r, loss_r, loopled_r, blkled_r;
	logic [PSLI_NCMD-1:0] ctx_r, ctx_nxt, crx_r, crx_nxt;
	logic [PSLI_NSPEECH-1:0] stx_r, stx_nxt, srx_r, srx_nxt;

	// blocked has no source but signal loss here, so both flags always agree
	always_comb
	begin
		gok_nxt = ~ghi_s & ~glo_s;
		loss_nxt = gloss_r | puloss_r;
		blk_nxt = loss_nxt;
		alarm_nxt = blk_nxt | loss_nxt | snr_s | (ghi_s | glo_s) | tfail_s
			| derr_s | mblk_s | cfg_s;
		loopled_nxt = ltst_s;
		blkled_nxt = blk_nxt | mgmt_s;
		ctx_nxt = ctx_s;
		crx_nxt = crx_s;
		stx_nxt = stx_s;
		srx_nxt = srx_s;
	end

	// port led registers
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ptx_r <= '0;
			prx_r <= '0;
		end
		else
		begin
			ptx_r <= ptx_nxt;
			prx_r <= prx_nxt;
		end
	end

	// guard loss timer registers
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			gl_r <= PSLI_MS_ZERO;
			gloss_r <= 1'b0;
		end
		else
		begin
			gl_r <= gl_nxt;
			gloss_r <= gloss_nxt;
		end
	end

	// power-up window registers; the window opens armed out of reset
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pu_r <= PSLI_MS_ZERO;
			puloss_r <= 1'b0;
			pwrup_r <= 1'b1;
		end
		else
		begin
			pu_r <= pu_nxt;
			puloss_r <= puloss_nxt;
			pwrup_r <= pwrup_nxt;
		end
	end

	// test result registers
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			tst_r <= PSLI_TST_NONE;
			tgreen_r <= 1'b0;
			tred_r <= 1'b0;
		end
		else
		begin
			tst_r <= tst_nxt;
			tgreen_r <= tgreen_nxt;
			tred_r <= tred_nxt;
		end
	end

	// teleprotection and speech led registers
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			blk_r <= 1'b0;
			alarm_r <= 1'b0;
			gok_r <= 1'b0;
			loss_r <= 1'b0;
			loopled_r <= 1'b0;
			blkled_r <= 1'b0;
			ctx_r <= '0;
			crx_r <= '0;
			stx_r <= '0;
			srx_r <= '0;
		end
		else
		begin
			blk_r <= blk_nxt;
			alarm_r <= alarm_nxt;
			gok_r <= gok_nxt;
			loss_r <= loss_nxt;
			loopled_r <= loopled_nxt;
			blkled_r <= blkled_nxt;
			ctx_r <= ctx_nxt;
			crx_r <= crx_nxt;
			stx_r <= stx_nxt;
			srx_r <= srx_nxt;
		end
	end

	assign o_port_tx_led = ptx_r;
	assign o_port_rx_led = prx_r;
	assign o_speech_tx_led = stx_r;
	assign o_speech_rx_led = srx_r;
	assign o_guard_level_ok_led = gok_r;
	assign o_signal_loss_led = loss_r;
	assign o_rx_blocked = blk_r;
	assign o_terminal_alarm_led = alarm_r;
	assign o_loop_led = loopled_r;
	assign o_blocking_led = blkled_r;
	assign o_test_green_led = tgreen_r;
	assign o_test_red_led = tred_r;
	assign o_command_transmit_leds = ctx_r;
	assign o_command_receive_leds = crx_r;
endmodule

// file: design/psli_pkg.sv
// constants for the port status led indicator
package psli_pkg;
	localparam int PSLI_CLK_HZ = 25000000;
	localparam int PSLI_NPORT = 4;
	localparam int PSLI_NSPEECH = 4;
	localparam int PSLI_NCMD = 4;
	// blink half periods in milliseconds
	localparam int PSLI_LOOP_HALF_MS = 500;
	localparam int PSLI_DIS_HALF_MS = 200;
	localparam int PSLI_TICK_HZ = 1000;
	localparam int PSLI_TICK_CYC = PSLI_CLK_HZ / PSLI_TICK_HZ;
	localparam int PSLI_GUARD_LOSS_MS = 50;
	localparam int PSLI_PWRUP_LOSS_MS = 500;
	localparam int PSLI_MS_W = 10;
	localparam int PSLI_TICK_W = 16;
	localparam logic [PSLI_MS_W-1:0] PSLI_MS_ZERO = 10'h000;
	localparam logic [PSLI_TICK_W-1:0] PSLI_TICK_ZERO = 16'h0000;
	typedef enum logic [1:0] {
		PSLI_TST_NONE = 2'b00,
		PSLI_TST_PASS = 2'b01,
		PSLI_TST_FAIL = 2'b10
	} psli_test_t;
endpackage

// file: design/psli_timebase.sv
// free-running millisecond tick and the two blink phases
`timescale 1ns/100ps
module psli_timebase
	import psli_pkg::*;
#(
	parameter int TICK_CYC = PSLI_TICK_CYC
)
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	output logic o_tick,
	output logic o_loop_phase,
	output logic o_dis_phase
);
	logic [PSLI_TICK_W-1:0] div_r, div_nxt;
	logic [PSLI_MS_W-1:0] loop_r, loop_nxt, dis_r, dis_nxt;
	logic tick_r, tick_nxt, lph_r, lph_nxt, dph_r, dph_nxt;

	// counters never stop, so blink phase is shared by all ports
	always_comb
	begin
		div_nxt = div_r + 16'h0001;
		tick_nxt = 1'b0;
		loop_nxt = loop_r;
		dis_nxt = dis_r;
		lph_nxt = lph_r;
		dph_nxt = dph_r;
		if (div_r == PSLI_TICK_W'(TICK_CYC - 1))
		begin
			div_nxt = PSLI_TICK_ZERO;
			tick_nxt = 1'b1;
			loop_nxt = loop_r + 10'h001;
			dis_nxt = dis_r + 10'h001;
			if (loop_r == PSLI_MS_W'(PSLI_LOOP_HALF_MS - 1))
			begin
				loop_nxt = PSLI_MS_ZERO;
				lph_nxt = ~lph_r;
			end
			if (dis_r == PSLI_MS_W'(PSLI_DIS_HALF_MS - 1))
			begin
				dis_nxt = PSLI_MS_ZERO;
				dph_nxt = ~dph_r;
			end
		end
	end

	// register stage
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			div_r <= PSLI_TICK_ZERO;
			loop_r <= PSLI_MS_ZERO;
			dis_r <= PSLI_MS_ZERO;
			tick_r <= 1'b0;
			lph_r <= 1'b0;
			dph_r <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			loop_r <= loop_nxt;
			dis_r <= dis_nxt;
			tick_r <= tick_nxt;
			lph_r <= lph_nxt;
			dph_r <= dph_nxt;
		end
	end

	assign o_tick = tick_r;
	assign o_loop_phase = lph_r;
	assign o_dis_phase = dph_r;
endmodule

// file: design/psli_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module psli_sync
#(
	parameter int W = 1
)
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] s1_r, s2_r;

	// first stage feeds only the second
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			s1_r <= '0;
			s2_r <= '0;
		end
		else
		begin
			s1_r <= i_async;
			s2_r <= s1_r;
		end
	end

	assign o_sync = s2_r;
endmodule

// file: sim/psli_checker.sv
// concurrent checks on the led outputs of the indicator top
`timescale 1ns/100ps
module psli_checker
	import psli_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic [PSLI_NPORT-1:0] i_port_txd,
	input wire logic [PSLI_NPORT-1:0] i_port_rxd,
	input wire logic [PSLI_NPORT-1:0] i_port_loop,
	input wire logic [PSLI_NPORT-1:0] i_port_disabled,
	input wire logic [PSLI_NPORT-1:0] o_port_tx_led,
	input wire logic [PSLI_NPORT-1:0] o_port_rx_led,
	input wire logic i_guard_high,
	input wire logic i_guard_low,
	input wire logic i_low_snr,
	input wire logic i_device_error,
	input wire logic i_mgmt_out_block,
	input wire logic i_loop_test_active,
	input wire logic o_guard_level_ok_led,
	input wire logic o_signal_loss_led,
	input wire logic o_rx_blocked,
	input wire logic o_terminal_alarm_led,
	input wire logic o_loop_led,
	input wire logic o_blocking_led,
	input wire logic o_test_green_led,
	input wire logic o_test_red_led
);
	logic [2:0] up_r;
	logic [2:0] up_nxt;
	logic ok;
	// outputs only mean something once the sync pipe refilled after reset
	always_comb
	begin
		up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
	end
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			up_r <= 3'h0;
		else
			up_r <= up_nxt;
	end
	assign ok = (up_r == 3'h7);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	// plain activity mode held long enough to reach the leds
	sequence s_plain;
		(ok && i_port_loop == 4'h0 && i_port_disabled == 4'h0)[*4];
	endsequence
	sequence s_loop;
		(ok && i_port_loop == 4'hF && i_port_disabled == 4'h0)[*4];
	endsequence
	sequence s_dis;
		(ok && i_port_disabled == 4'hF)[*4];
	endsequence
	a_tx_led_mirror: assert property (s_plain |-> o_port_tx_led == ~$past(i_port_txd, 3))
		else $error("tx led does not follow line");
	a_rx_led_mirror: assert property (s_plain |-> o_port_rx_led == ~$past(i_port_rxd, 3))
		else $error("rx led does not follow line");
	a_loop_alternate: assert property (s_loop |-> o_port_tx_led == ~o_port_rx_led)
		else $error("loop leds not in opposite phase");
	a_dis_together: assert property (s_dis |-> o_port_tx_led == o_port_rx_led)
		else $error("disabled leds not in phase");
	a_guard_window: assert property (ok |->
		o_guard_level_ok_led == !($past(i_guard_high, 3) || $past(i_guard_low, 3)))
		else $error("guard led wrong");
	a_loss_blocks: assert property (o_signal_loss_led |-> o_rx_blocked)
		else $error("loss without blocked receiver");
	a_alarm_source: assert property (ok && $past(i_low_snr || i_device_error, 3)
		|-> o_terminal_alarm_led)
		else $error("alarm led missing");
	a_loop_led: assert property (ok |-> o_loop_led == $past(i_loop_test_active, 3))
		else $error("loop led wrong");
	a_mgmt_block: assert property (ok && $past(i_mgmt_out_block, 3) |-> o_blocking_led)
		else $error("blocking led missing");
	a_test_colour: assert property (!(o_test_green_led && o_test_red_led))
		else $error("test led both colours");
endmodule
bind psli_top psli_checker chk (.i_mclk(i_mclk), .i_resetn(i_resetn),
	.i_port_txd(i_port_txd), .i_port_rxd(i_port_rxd), .i_port_loop(i_port_loop),
	.i_port_disabled(i_port_disabled), .o_port_tx_led(o_port_tx_led),
	.o_port_rx_led(o_port_rx_led), .i_guard_high(i_guard_high), .i_guard_low(i_guard_low),
	.i_low_snr(i_low_snr), .i_device_error(i_device_error),
	.i_mgmt_out_block(i_mgmt_out_block), .i_loop_test_active(i_loop_test_active),
	.o_guard_level_ok_led(o_guard_level_ok_led), .o_signal_loss_led(o_signal_loss_led),
	.o_rx_blocked(o_rx_blocked), .o_terminal_alarm_led(o_terminal_alarm_led),
	.o_loop_led(o_loop_led), .o_blocking_led(o_blocking_led),
	.o_test_green_led(o_test_green_led), .o_test_red_led(o_test_red_led));

// file: sim/psli_lamp.sv
// lamp model: measures how many cycles a front lamp kept its last state
`timescale 1ns/100ps
module psli_lamp
(
	input wire logic i_mclk,
	input wire logic i_lamp,
	output logic [15:0] o_run
);
	logic prev_r = 1'b0;
	logic [15:0] cnt_r = 16'h0000;
	// the first run after a mode change is partial, so read it late
	always @(posedge i_mclk)
	begin
		prev_r <= i_lamp;
		cnt_r <= (i_lamp != prev_r) ? 16'h0001 : cnt_r + 16'h0001;
		if (i_lamp != prev_r)
			o_run <= cnt_r;
	end
endmodule

// file: sim/psli_top_test.sv
// self-checking bench for the port status led indicator
`timescale 1ns/100ps
module psli_top_test;
	import psli_pkg::*;
	localparam int TK = 10;
	logic i_mclk = 1'b0, i_resetn = 1'b0;
	logic [3:0] i_port_txd = 4'h0, i_port_rxd = 4'h0, i_port_loop = 4'h0;
	logic [3:0] i_port_disabled = 4'h0, i_speech_tx_wire = 4'h0, i_speech_rx_wire = 4'h0;
	logic [3:0] i_cmd_tx = 4'h0, i_cmd_rx = 4'h0;
	logic [6:0] src = 7'h00;
	logic i_guard_below_min = 1'b0, i_signal_present = 1'b0, i_mgmt_out_block = 1'b0;
	logic i_loop_test_active = 1'b0, i_test_done = 1'b0, i_test_pass = 1'b0;
	logic [3:0] o_port_tx_led, o_port_rx_led, o_speech_tx_led, o_speech_rx_led;
	logic [3:0] o_command_transmit_leds, o_command_receive_leds;
	logic o_guard_level_ok_led, o_signal_loss_led, o_rx_blocked, o_terminal_alarm_led;
	logic o_loop_led, o_blocking_led, o_test_green_led, o_test_red_led;
	logic [15:0] run;
	int n_fail = 0, tests_run = 0, cyc = 0;
	psli_top #(.TICK_CYC(TK)) uut (.i_mclk(i_mclk), .i_resetn(i_resetn),
		.i_port_txd(i_port_txd), .i_port_rxd(i_port_rxd), .i_port_loop(i_port_loop),
		.i_port_disabled(i_port_disabled), .o_port_tx_led(o_port_tx_led),
		.o_port_rx_led(o_port_rx_led), .i_speech_tx_wire(i_speech_tx_wire),
		.i_speech_rx_wire(i_speech_rx_wire), .o_speech_tx_led(o_speech_tx_led),
		.o_speech_rx_led(o_speech_rx_led), .i_guard_high(src[1]), .i_guard_low(src[0]),
		.i_guard_below_min(i_guard_below_min), .i_signal_present(i_signal_present),
		.i_cmd_tx(i_cmd_tx), .i_cmd_rx(i_cmd_rx), .i_low_snr(src[6]),
		.i_test_fail_alarm(src[5]), .i_device_error(src[4]), .i_manual_block(src[3]),
		.i_config_bad(src[2]), .i_mgmt_out_block(i_mgmt_out_block),
		.i_loop_test_active(i_loop_test_active), .i_test_done(i_test_done),
		.i_test_pass(i_test_pass), .o_guard_level_ok_led(o_guard_level_ok_led),
		.o_signal_loss_led(o_signal_loss_led), .o_rx_blocked(o_rx_blocked),
		.o_terminal_alarm_led(o_terminal_alarm_led), .o_loop_led(o_loop_led),
		.o_blocking_led(o_blocking_led), .o_test_green_led(o_test_green_led),
		.o_test_red_led(o_test_red_led), .o_command_transmit_leds(o_command_transmit_leds),
		.o_command_receive_leds(o_command_receive_leds));
	psli_lamp lamp (.i_mclk(i_mclk), .i_lamp(o_port_tx_led[0]), .o_run(run));
	// 25 MHz clock
	always #20 i_mclk = ~i_mclk;
	task automatic w(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// compare a little after the edge so that edge's updates have landed
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		#1;
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard: the full sequence needs about 21000 cycles
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			wrap_up();
		end
	end
	initial
	begin
		w(16);
		i_resetn <= 1'b1;
		w(4900);
		chk(o_signal_loss_led, 1'b0);
		w(200);
		chk({o_signal_loss_led, o_rx_blocked, o_terminal_alarm_led, o_blocking_led}, 4'hF);
		w(1);
		i_signal_present <= 1'b1;
		i_port_txd <= 4'hA;
		i_port_rxd <= 4'h5;
		i_speech_tx_wire <= 4'h3;
		i_speech_rx_wire <= 4'hC;
		i_cmd_tx <= 4'h9;
		i_cmd_rx <= 4'h6;
		i_loop_test_active <= 1'b1;
		w(6);
		chk({o_signal_loss_led, o_terminal_alarm_led, o_guard_level_ok_led}, 3'h1);
		chk({o_port_tx_led, o_port_rx_led}, 8'h5A);
		chk({o_speech_tx_led, o_speech_rx_led}, 8'h3C);
		chk({o_command_transmit_leds, o_command_receive_leds}, 8'h96);
		chk(o_loop_led, 1'b1);
		chk({o_rx_blocked, o_blocking_led, o_test_green_led, o_test_red_led}, 4'h0);
		// each of the seven pin alarm sources alone, guard window edges among them
		for (int i = 0; i < 7; i++)
		begin
			w(1);
			src <= 7'h01 << i;
			w(5);
			chk(o_terminal_alarm_led, 1'b1);
			chk(o_guard_level_ok_led, i > 1);
		end
		w(1);
		src <= 7'h00;
		i_mgmt_out_block <= 1'b1;
		w(5);
		chk({o_blocking_led, o_terminal_alarm_led}, 2'h2);
		for (int i = 0; i < 2; i++)
		begin
			w(1);
			i_test_pass <= (i == 0);
			i_test_done <= 1'b1;
			w(1);
			i_test_done <= 1'b0;
			w(5);
			chk({o_test_green_led, o_test_red_led}, (i == 0) ? 2'h2 : 2'h1);
		end
		w(1);
		i_cmd_rx <= 4'h0;
		i_guard_below_min <= 1'b1;
		w(460);
		chk(o_signal_loss_led, 1'b0);
		w(60);
		chk({o_signal_loss_led, o_rx_blocked}, 2'h3);
		w(1);
		i_cmd_rx <= 4'h1;
		w(5);
		chk(o_signal_loss_led, 1'b0);
		w(1);
		i_port_loop <= 4'hF;
		w(11000);
		chk(run, 16'(500 * TK));
		chk(o_port_tx_led ^ o_port_rx_led, 4'hF);
		w(1);
		i_port_disabled <= 4'hF;
		w(4500);
		chk(run, 16'(200 * TK));
		chk(o_port_tx_led ^ o_port_rx_led, 4'h0);
		wrap_up();
	end
endmodule
